// >>> dv/scs_osc_model.sv
// external oscillator activity and pll lock model
`timescale 1ns/1ps
module scs_osc_model
(
	input wire sys_clk,
	input wire nrst,
	input wire osc_en,
	input wire pll_en,
	input wire run,
	input wire lock_ok,
	output reg ext_clk_tick,
	output reg pll_lock
);
	reg [1:0] ph;
	reg [3:0] wc;
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ph <= 2'h0;
			wc <= 4'h0;
			ext_clk_tick <= 1'b0;
			pll_lock <= 1'b0;
		end
		else
		begin
			ext_clk_tick <= osc_en && run && ph == 2'h0;
			ph <= (ph == 2'h0) ? 2'($urandom) : ph - 2'h1;
			wc <= !(pll_en && lock_ok) ? 4'h0 : wc + {3'h0, wc != 4'hf};
			pll_lock <= wc == 4'hf;
		end
	end
endmodule

// >>> dv/scs_top_asserts.sv
// concurrent checks on the clock select ports
`timescale 1ns/1ps
module scs_top_asserts
(
	input wire sys_clk,
	input wire nrst,
	input wire rd,
	input wire [31:0] rdata,
	input wire ext_clk_tick,
	input wire stop_req,
	input wire internal_fast_rc_en,
	input wire external_fast_oscillator_en,
	input wire pll_en,
	input wire gate_rc,
	input wire gate_ext,
	input wire gate_pll,
	input wire clk_fail_irq,
	input wire pll_fail_irq
);
	reg [7:0] idle;
	wire none = !(gate_rc | gate_ext | gate_pll);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_gap;
		none [*2];
	endsequence
	always @(posedge sys_clk or negedge nrst)
		if (!nrst)
			idle <= 8'h00;
		else if (!gate_ext || ext_clk_tick)
			idle <= 8'h00;
		else if (idle != 8'hff)
			idle <= idle + 8'h01;
	a_one_gate: assert property ($onehot0({gate_rc, gate_ext, gate_pll}))
		else $error("two clock gates open");
	a_gap_after: assert property ($fell(gate_rc) || $fell(gate_ext) || $fell(gate_pll) |-> s_gap)
		else $error("no gap after gate close");
	a_gap_before: assert property ($rose(gate_rc) || $rose(gate_ext) || $rose(gate_pll)
		|-> $past(none, 1) && $past(none, 2))
		else $error("gate opened without gap");
	a_fail_drop: assert property (idle < 8'h38)
		else $error("dead external clock still gated");
	a_ext_used: assert property (gate_ext |-> external_fast_oscillator_en)
		else $error("external gated while disabled");
	a_pll_used: assert property (gate_pll |-> pll_en)
		else $error("pll gated while disabled");
	a_ext_irq: assert property (clk_fail_irq |-> !gate_ext)
		else $error("failed external reselected");
	a_pll_irq: assert property (pll_fail_irq |-> !gate_pll)
		else $error("failed pll reselected");
	a_stop_off: assert property (stop_req ##1 stop_req
		|-> !pll_en && !external_fast_oscillator_en && !internal_fast_rc_en)
		else $error("oscillator on in stop");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule
bind scs_top scs_top_asserts chk_u (.sys_clk, .nrst, .rd, .rdata, .ext_clk_tick, .stop_req,
	.internal_fast_rc_en, .external_fast_oscillator_en, .pll_en, .gate_rc, .gate_ext,
	.gate_pll, .clk_fail_irq, .pll_fail_irq);

// >>> dv/tb_top.sv
// self-checking bench for the clock select block
`timescale 1ns/1ps
module tb_top;
	reg sys_clk = 1'b0;
	reg nrst = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg rd_d = 1'b0;
	reg stop_req = 1'b0;
	reg run = 1'b1;
	reg lock_ok = 1'b1;
	wire [31:0] rdata;
	wire tk, lk, rc_en, ext_en, pll_en, g_rc, g_ext, g_pll, ahb, apb1, apb2, irq, pirq;
	integer error_cnt = 0;
	integer compares = 0;
	integer i, k, n, j;
	reg [63:0] exp_q[$];
	reg [63:0] e;
	scs_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ext_clk_tick(tk), .pll_lock(lk), .stop_req(stop_req),
		.internal_fast_rc_en(rc_en), .external_fast_oscillator_en(ext_en), .pll_en(pll_en),
		.gate_rc(g_rc), .gate_ext(g_ext), .gate_pll(g_pll), .ahb_tick(ahb), .apb1_tick(apb1),
		.apb2_tick(apb2), .clk_fail_irq(irq), .pll_fail_irq(pirq));
	scs_osc_model osc_u (.sys_clk(sys_clk), .nrst(nrst), .osc_en(ext_en), .pll_en(pll_en),
		.run(run), .lock_ok(lock_ok), .ext_clk_tick(tk), .pll_lock(lk));
	initial forever #10 sys_clk = ~sys_clk;
	task cmp(input [31:0] got, input [31:0] exp);
	begin
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr_reg(input [7:0] a, input [31:0] d);
	begin
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	end
	endtask
	task rd_reg(input [7:0] a, input [31:0] m, input [31:0] x);
	begin
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back({m, x});
		@(posedge sys_clk);
		rd <= 1'b0;
	end
	endtask
	task report_and_stop;
	begin
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	always @(posedge sys_clk)
		rd_d <= rd;
	always @(negedge sys_clk)
		if (rd_d)
		begin
			e = exp_q.pop_front();
			cmp(rdata & e[63:32], e[31:0]);
		end
	initial
	begin
		#100000;
		error_cnt++;
		report_and_stop;
	end
	initial
	begin
		n = $urandom(32'hef30);
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		rd_reg(8'h08, 32'hffffffff, 32'h0);
		rd_reg(8'h00, 32'hffffffff, 32'h0);
		rd_reg(8'h0c, 32'hffffffff, 32'h0);
		cmp(g_rc, 32'h1);
		$display("reset test done");
		n = $urandom % 4;
		// ahb code keeps the bus in range
		wr_reg(8'h04, n * 65 + 8);
		repeat (4) @(posedge sys_clk);
		i = 0;
		k = 0;
		j = 0;
		repeat (64)
		begin
			@(negedge sys_clk);
			i += ahb;
			k += apb1;
			j += apb2;
		end
		cmp(i, 64 >> n);
		cmp(k, 32);
		cmp(j, 64 >> n);
		rd_reg(8'h04, 32'hffffffff, n * 65 + 8);
		$display("prescaler test done");
		for (i = 1; i >= 0; i--)
		begin
			wr_reg(8'h00, 32'h05 | (i << 4));
			repeat (40) @(posedge sys_clk);
			cmp(g_ext, 32'h1);
			run <= 1'b0;
			repeat (80) @(posedge sys_clk);
			rd_reg(8'h08, 32'h7, 32'h4);
			rd_reg(8'h00, 32'h3, 32'h0);
			cmp(irq, i);
			run <= 1'b1;
			wr_reg(8'h08, 32'h4);
			repeat (40) @(posedge sys_clk);
			cmp(g_ext, 32'h0);
			cmp(irq, 32'h0);
		end
		$display("failure test done");
		wr_reg(8'h00, 32'h2a);
		repeat (40) @(posedge sys_clk);
		cmp(g_pll, 32'h1);
		lock_ok <= 1'b0;
		repeat (20) @(posedge sys_clk);
		cmp(pirq, 32'h1);
		cmp(g_rc, 32'h1);
		lock_ok <= 1'b1;
		$display("pll test done");
		stop_req <= 1'b1;
		repeat (6) @(posedge sys_clk);
		cmp(pll_en, 32'h0);
		cmp(rc_en, 32'h0);
		stop_req <= 1'b0;
		repeat (3) @(posedge sys_clk);
		cmp(rc_en, 32'h1);
		$display("stop test done");
		report_and_stop;
	end
endmodule

// >>> src/scs_defines.vh
// constants for the system clock select and monitor block
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH

`define SCS_AW 8
`define SCS_DW 32

`define SCS_OFF_CTRL 8'h00
`define SCS_OFF_DIV 8'h04
`define SCS_OFF_STAT 8'h08

`define SCS_SRC_RC 2'h0
`define SCS_SRC_EXT 2'h1
`define SCS_SRC_PLL 2'h2

`define SCS_CTRL_SRC_LO 0
`define SCS_CTRL_SRC_HI 1
`define SCS_CTRL_EXT_EN 2
`define SCS_CTRL_PLL_EN 3
`define SCS_CTRL_FAIL_IE 4
`define SCS_CTRL_PLL_IE 5
`define SCS_CTRL_W 6
`define SCS_CTRL_RST 6'h00

`define SCS_DIV_AHB_LO 0
`define SCS_DIV_APB1_LO 3
`define SCS_DIV_APB2_LO 6
`define SCS_DIV_FW 3
`define SCS_DIV_W 9
`define SCS_DIV_RST 9'h000

`define SCS_STAT_SRC_LO 0
`define SCS_STAT_SRC_HI 1
`define SCS_STAT_EXT_FAIL 2
`define SCS_STAT_PLL_FAIL 3
`define SCS_STAT_EXT_RDY 4
`define SCS_STAT_PLL_LOCK 5
`define SCS_STAT_BUSY 6
`define SCS_STAT_W 7

`define SCS_PRESC_W 7

`define SCS_CLK_MHZ 50
`define SCS_MON_TIMEOUT_NS 1000
`define SCS_MON_CYC ((`SCS_MON_TIMEOUT_NS * `SCS_CLK_MHZ) / 1000)
`define SCS_GAP_NS 40
`define SCS_GAP_CYC (((`SCS_GAP_NS * `SCS_CLK_MHZ) + 999) / 1000)
`define SCS_CNT_W 8

`endif

// >>> src/scs_presc.v
// power-of-two prescaler producing a one-cycle domain tick
`timescale 1ns/1ps
`include "scs_defines.vh"

module scs_presc
(
	input wire sys_clk,
	input wire nrst,
	input wire [`SCS_DIV_FW-1:0] div_code,
	input wire run,
	output reg tick
);
	reg [`SCS_PRESC_W-1:0] cnt;
	wire [`SCS_PRESC_W-1:0] mask;

	assign mask = ~({`SCS_PRESC_W{1'b1}} << div_code);

	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt <= {`SCS_PRESC_W{1'b0}};
			tick <= 1'b0;
		end
		else if (!run)
		begin
			cnt <= {`SCS_PRESC_W{1'b0}};
			tick <= 1'b0;
		end
		else
		begin
			tick <= ((cnt & mask) == mask);
			cnt <= cnt + {{(`SCS_PRESC_W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// >>> src/scs_top.v
// system clock select, external clock monitor and bus prescalers
//
// Summary of operation
// - after reset the internal fast rc drives the system clock until software changes it.
// - software may select the external oscillator; while used it is watched for failure.
// - on external failure hardware falls back to the internal fast rc by itself.
// - an external failure raises an interrupt only when its enable is set.
// - loss of pll lock while enabled is flagged and may raise its own interrupt.
// - ahb, apb1 and apb2 ticks come from separate programmable prescalers.
// - stop entry disables the pll, internal fast rc and external oscillator.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "scs_defines.vh"

module scs_top
(
	input wire sys_clk,
	input wire nrst,
	input wire [`SCS_AW-1:0] addr,
	input wire [`SCS_DW-1:0] wdata,
	input wire wr,
	input wire rd,
	output reg [`SCS_DW-1:0] rdata,
	input wire ext_clk_tick,
	input wire pll_lock,
	input wire stop_req,
	output reg internal_fast_rc_en,
	output reg external_fast_oscillator_en,
	output reg pll_en,
	output reg gate_rc,
	output reg gate_ext,
	output reg gate_pll,
	output reg ahb_tick,
	output reg apb1_tick,
	output reg apb2_tick,
	output reg clk_fail_irq,
	output reg pll_fail_irq
);
	localparam ST_RUN = 1'b0;
	localparam ST_GAP = 1'b1;

	reg [`SCS_CTRL_W-1:0] ctrl;
	reg [`SCS_DIV_W-1:0] div;
	reg ext_fail;
	reg pll_fail;
	reg state;
	reg [1:0] cur_src;
	reg [1:0] pend_src;
	reg [`SCS_CNT_W-1:0] gap_cnt;
	reg [`SCS_CNT_W-1:0] mon_cnt;
	reg ext_seen;
	reg pll_run;
	reg [`SCS_STAT_W-1:0] stat;

	wire ext_on;
	wire pll_on;
	wire ext_ready;
	wire pll_ready;
	wire ext_dead;
	wire pll_lost;
	wire wr_ctrl;
	wire wr_stat;
	wire [1:0] req_src;
	wire req_ok;
	wire busy;
	wire [2:0] presc_tick;
	wire fall_rc;

	assign wr_ctrl = wr && (addr == `SCS_OFF_CTRL);
	assign wr_stat = wr && (addr == `SCS_OFF_STAT);
	// stop entry
	// oscillators off
	assign ext_on = ctrl[`SCS_CTRL_EXT_EN] && !stop_req;
	assign pll_on = ctrl[`SCS_CTRL_PLL_EN] && !stop_req;
	assign ext_ready = ext_on && ext_seen && (mon_cnt < `SCS_MON_CYC);
	assign pll_ready = pll_on && pll_lock;
	assign ext_dead = ext_on && ext_seen && (mon_cnt >= `SCS_MON_CYC)
		&& (cur_src != `SCS_SRC_RC || pend_src != `SCS_SRC_RC);
	assign pll_lost = pll_run && pll_on && !pll_lock;
	assign req_src = ctrl[`SCS_CTRL_SRC_HI:`SCS_CTRL_SRC_LO];
	assign req_ok = (req_src == `SCS_SRC_RC)
		|| (req_src == `SCS_SRC_EXT && ext_ready && !ext_fail)
		|| (req_src == `SCS_SRC_PLL && pll_ready && !pll_fail);
	assign busy = (state == ST_GAP);
	// close a gate on the same edge that its source is switched off, or once it is lost
	assign fall_rc = ext_dead || (pll_lost && (cur_src == `SCS_SRC_PLL || pend_src == `SCS_SRC_PLL))
		|| ((cur_src == `SCS_SRC_EXT || pend_src == `SCS_SRC_EXT) && !ext_on)
		|| ((cur_src == `SCS_SRC_PLL || pend_src == `SCS_SRC_PLL) && !pll_on);

	// external oscillator activity watchdog
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mon_cnt <= {`SCS_CNT_W{1'b0}};
			ext_seen <= 1'b0;
			pll_run <= 1'b0;
		end
		else
		begin
			pll_run <= pll_on && (pll_run || pll_lock);
			if (!ext_on)
			begin
				mon_cnt <= {`SCS_CNT_W{1'b0}};
				ext_seen <= 1'b0;
			end
			else if (ext_clk_tick)
			begin
				mon_cnt <= {`SCS_CNT_W{1'b0}};
				ext_seen <= 1'b1;
			end
			else if (mon_cnt < `SCS_MON_CYC)
				mon_cnt <= mon_cnt + {{(`SCS_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// registers and sticky flags
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl <= `SCS_CTRL_RST;
			div <= `SCS_DIV_RST;
			ext_fail <= 1'b0;
			pll_fail <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= wdata[`SCS_CTRL_W-1:0];
			if (wr && addr == `SCS_OFF_DIV)
				div <= wdata[`SCS_DIV_W-1:0];
			if (ext_dead || (pll_lost && cur_src == `SCS_SRC_PLL) || stop_req)
				ctrl[`SCS_CTRL_SRC_HI:`SCS_CTRL_SRC_LO] <= `SCS_SRC_RC;
			if (ext_dead)
				ext_fail <= 1'b1;
			else if (wr_stat && wdata[`SCS_STAT_EXT_FAIL])
				ext_fail <= 1'b0;
			if (pll_lost)
				pll_fail <= 1'b1;
			else if (wr_stat && wdata[`SCS_STAT_PLL_FAIL])
				pll_fail <= 1'b0;
		end
	end

	// source switch sequencer
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= ST_RUN;
			cur_src <= `SCS_SRC_RC;
			pend_src <= `SCS_SRC_RC;
			gap_cnt <= {`SCS_CNT_W{1'b0}};
			gate_rc <= 1'b1;
			gate_ext <= 1'b0;
			gate_pll <= 1'b0;
		end
		else
		begin
			case (state)
				ST_RUN:
				begin
					gap_cnt <= {`SCS_CNT_W{1'b0}};
					if (fall_rc && cur_src != `SCS_SRC_RC)
					begin
						pend_src <= `SCS_SRC_RC;
						state <= ST_GAP;
						gate_rc <= 1'b0;
						gate_ext <= 1'b0;
						gate_pll <= 1'b0;
					end
					else if (req_src != cur_src && req_ok)
					begin
						pend_src <= req_src;
						state <= ST_GAP;
						gate_rc <= 1'b0;
						gate_ext <= 1'b0;
						gate_pll <= 1'b0;
					end
				end
				ST_GAP:
				begin
					if (fall_rc)
						pend_src <= `SCS_SRC_RC;
					if (gap_cnt >= `SCS_GAP_CYC)
					begin
						cur_src <= fall_rc ? `SCS_SRC_RC : pend_src;
						gate_rc <= (fall_rc || pend_src == `SCS_SRC_RC);
						gate_ext <= !fall_rc && pend_src == `SCS_SRC_EXT;
						gate_pll <= !fall_rc && pend_src == `SCS_SRC_PLL;
						state <= ST_RUN;
					end
					else
						gap_cnt <= gap_cnt + {{(`SCS_CNT_W-1){1'b0}}, 1'b1};
				end
				default:
				begin
					state <= ST_RUN;
					cur_src <= `SCS_SRC_RC;
					gate_rc <= 1'b1;
					gate_ext <= 1'b0;
					gate_pll <= 1'b0;
				end
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_presc
			scs_presc u_presc
			(
				.sys_clk(sys_clk),
				.nrst(nrst),
				.div_code(div[gi*`SCS_DIV_FW +: `SCS_DIV_FW]),
				.run(!busy),
				.tick(presc_tick[gi])
			);
		end
	endgenerate

	always @*
	begin
		stat = {`SCS_STAT_W{1'b0}};
		stat[`SCS_STAT_SRC_HI:`SCS_STAT_SRC_LO] = cur_src;
		stat[`SCS_STAT_EXT_FAIL] = ext_fail;
		stat[`SCS_STAT_PLL_FAIL] = pll_fail;
		stat[`SCS_STAT_EXT_RDY] = ext_ready;
		stat[`SCS_STAT_PLL_LOCK] = pll_ready;
		stat[`SCS_STAT_BUSY] = busy;
	end

	// outputs, read port
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata <= {`SCS_DW{1'b0}};
			internal_fast_rc_en <= 1'b1;
			external_fast_oscillator_en <= 1'b0;
			pll_en <= 1'b0;
			ahb_tick <= 1'b0;
			apb1_tick <= 1'b0;
			apb2_tick <= 1'b0;
			clk_fail_irq <= 1'b0;
			pll_fail_irq <= 1'b0;
		end
		else
		begin
			internal_fast_rc_en <= !stop_req;
			external_fast_oscillator_en <= ext_on;
			pll_en <= pll_on;
			ahb_tick <= presc_tick[0];
			apb1_tick <= presc_tick[1];
			apb2_tick <= presc_tick[2];
			clk_fail_irq <= ext_fail && ctrl[`SCS_CTRL_FAIL_IE];
			pll_fail_irq <= pll_fail && ctrl[`SCS_CTRL_PLL_IE];
			if (!rd)
				rdata <= {`SCS_DW{1'b0}};
			else if (addr == `SCS_OFF_CTRL)
				rdata <= {{(`SCS_DW-`SCS_CTRL_W){1'b0}}, ctrl};
			else if (addr == `SCS_OFF_DIV)
				rdata <= {{(`SCS_DW-`SCS_DIV_W){1'b0}}, div};
			else if (addr == `SCS_OFF_STAT)
				rdata <= {{(`SCS_DW-`SCS_STAT_W){1'b0}}, stat};
			else
				rdata <= {`SCS_DW{1'b0}};
		end
	end
endmodule
